// >>> design/eab_pkg.sv
// Constants, register map and enumerations of the embedded array block.
// Assumes one 250 MHz core clock and an APB master for configuration.
package eab_pkg;

  // ==========================================================================
  // Sizes
  localparam int NUM_MC = 16;
  localparam int NUM_PT = 32;
  localparam int NUM_IN = 32;
  localparam int NUM_GLB = 4;
  localparam int MEM_DEPTH = 16;
  localparam int MEM_AW = 4;
  localparam int MEM_DW = 8;
  localparam int MC_CFG_W = 12;
  localparam int CNT_W = 5;
  localparam int APB_AW = 12;

  // ==========================================================================
  // Register map, byte addresses
  localparam logic [APB_AW-1:0] ADDR_CTRL = 12'h000;
  localparam logic [APB_AW-1:0] ADDR_STATUS = 12'h008;
  localparam logic [APB_AW-1:0] ADDR_PT_BASE = 12'h100;
  localparam logic [APB_AW-1:0] ADDR_PT_END = 12'h1FC;
  localparam logic [APB_AW-1:0] ADDR_MC_BASE = 12'h200;
  localparam logic [APB_AW-1:0] ADDR_MC_END = 12'h23C;
  localparam logic [APB_AW-1:0] ADDR_MEM_BASE = 12'h300;
  localparam logic [APB_AW-1:0] ADDR_MEM_END = 12'h33C;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  // Control word fields.
  localparam int CT_MEMMODE = 0;
  localparam int CT_KIND = 1;
  localparam int CT_OUTREG = 3;
  localparam int CT_REG_WDATA = 4;
  localparam int CT_REG_WADDR = 5;
  localparam int CT_REG_RADDR = 6;
  localparam int CT_REG_WE = 7;
  localparam int CT_REG_RE = 8;
  localparam int CT_CLR_INV = 10;
  localparam int CT_CLR_GLB = 12;
  localparam int CT_CLR_IDX0 = 14;
  localparam int CT_CLR_IDX1 = 16;

  // Macrocell configuration fields.
  localparam int MC_EXP0 = 0;
  localparam int MC_EXP1 = 1;
  localparam int MC_INV0 = 2;
  localparam int MC_COMB = 3;
  localparam int MC_CLR = 4;
  localparam int MC_PRESET = 6;
  localparam int MC_XOR = 7;
  localparam int MC_SETS = 8;

  // Status word fields.
  localparam int ST_COUNT = 16;
  localparam int ST_FULL = 21;
  localparam int ST_EMPTY = 22;
  localparam int ST_HIT = 23;

  typedef enum logic [1:0] {KIND_RAM, KIND_ROM, KIND_FIFO, KIND_SEARCH} eab_kind_t;
  typedef enum logic [1:0] {CLR_NONE, CLR_FIRST, CLR_SECOND, CLR_RSVD} eab_clr_t;

endpackage

// >>> design/eab_embedded_array_block.sv
// Embedded array block: sixteen product-term macrocells or a small memory.
// Assumes every input is synchronous to core_clk; slower user clocks arrive
// as one-cycle clock enables, configuration comes over APB.
`timescale 1ns/1ps
`default_nettype none

module eab_embedded_array_block (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [eab_pkg::APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [eab_pkg::NUM_IN-1:0] logicIn,
  input wire logic [eab_pkg::NUM_GLB-1:0] globalSig,
  input wire logic [1:0] clrLocal,
  input wire logic mcClkEn,
  output logic [eab_pkg::NUM_MC-1:0] mcOut,
  input wire logic wrClkEn,
  input wire logic wrEn,
  input wire logic [eab_pkg::MEM_AW-1:0] wrAddr,
  input wire logic [eab_pkg::MEM_DW-1:0] wrData,
  input wire logic rdClkEn,
  input wire logic memReadStrobe,
  input wire logic [eab_pkg::MEM_AW-1:0] rdAddr,
  input wire logic [eab_pkg::MEM_DW-1:0] searchKey,
  output logic [eab_pkg::MEM_DW-1:0] rdData,
  output logic rdValid,
  output logic searchHit,
  output logic fifoFull,
  output logic fifoEmpty
);
  import eab_pkg::*;

  // ==========================================================================
  // State
  typedef struct packed {
    logic [31:0] ctrl;
    logic [NUM_PT-1:0][NUM_IN-1:0] ptTrue;
    logic [NUM_PT-1:0][NUM_IN-1:0] ptComp;
    logic [NUM_MC-1:0][MC_CFG_W-1:0] mcCfg;
    logic [MEM_DEPTH-1:0][MEM_DW-1:0] mem;
    logic [NUM_MC-1:0] q;
    logic [NUM_MC-1:0] mcOut;
    logic [MEM_DW-1:0] wData;
    logic [MEM_AW-1:0] wAddr;
    logic wEn;
    logic [MEM_AW-1:0] rAddr;
    logic rEn;
    logic [MEM_DW-1:0] rdStage;
    logic rdStageVld;
    logic stageHit;
    logic [MEM_DW-1:0] rdData;
    logic rdValid;
    logic hit;
    logic [MEM_AW-1:0] wptr;
    logic [MEM_AW-1:0] rptr;
    logic [CNT_W-1:0] count;
    logic full;
    logic empty;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } eab_state_t;

  eab_state_t st_r;
  eab_state_t st_nxt;

  // ==========================================================================
  // Product terms and block clears
  logic [NUM_PT-1:0] ptVal;
  logic [NUM_MC-1:0] expOut;
  logic [NUM_MC-1:0] ownOr;
  logic [NUM_MC-1:0] dComb;
  logic [1:0] blkClr;
  logic [NUM_MC-1:0] mcClr;

  always_comb begin
    logic [NUM_IN-1:0] tm;
    logic [NUM_IN-1:0] cm;
    logic p0;
    logic p1;
    logic orAll;
    logic [3:0] nSets;
    logic [MC_CFG_W-1:0] cfg;
    logic [1:0] gIdx;
    logic src;
    tm = '0;
    cm = '0;
    p0 = 1'b0;
    p1 = 1'b0;
    orAll = 1'b0;
    nSets = '0;
    cfg = '0;
    gIdx = '0;
    src = 1'b0;
    for (int j = 0; j < NUM_PT; j++) begin
      tm = st_r.ptTrue[j];
      cm = st_r.ptComp[j];
      ptVal[j] = &(~tm | logicIn) & &(~cm | ~logicIn);
    end
    for (int m = 0; m < NUM_MC; m++) begin
      cfg = st_r.mcCfg[m];
      p0 = ptVal[2*m] ^ cfg[MC_INV0];
      p1 = ptVal[2*m+1];
      expOut[m] = (cfg[MC_EXP0] & p0) | (cfg[MC_EXP1] & p1);
      ownOr[m] = (~cfg[MC_EXP0] & p0) | (~cfg[MC_EXP1] & p1);
    end
    for (int m = 0; m < NUM_MC; m++) begin
      cfg = st_r.mcCfg[m];
      nSets = cfg[MC_SETS +: 4];
      orAll = ownOr[m];
      // Sets are borrowed from the following macrocells, wrapping round.
      for (int k = 0; k < NUM_MC - 1; k++) begin
        if (4'(k) < nSets) begin
          orAll = orAll | expOut[(m + 1 + k) % NUM_MC];
        end
      end
      dComb[m] = orAll ^ cfg[MC_XOR];
    end
    for (int c = 0; c < 2; c++) begin
      gIdx = (c == 0) ? st_r.ctrl[CT_CLR_IDX0 +: 2] : st_r.ctrl[CT_CLR_IDX1 +: 2];
      src = st_r.ctrl[CT_CLR_GLB + c] ? globalSig[gIdx] : clrLocal[c];
      blkClr[c] = src ^ st_r.ctrl[CT_CLR_INV + c];
    end
    for (int m = 0; m < NUM_MC; m++) begin
      cfg = st_r.mcCfg[m];
      unique case (eab_clr_t'(cfg[MC_CLR +: 2]))
        CLR_FIRST: mcClr[m] = blkClr[0];
        CLR_SECOND: mcClr[m] = blkClr[1];
        default: mcClr[m] = 1'b0;
      endcase
    end
  end

  // ==========================================================================
  // Next state
  always_comb begin
    logic setup;
    logic access;
    logic [MC_CFG_W-1:0] cfg;
    logic memMode;
    eab_kind_t kind;
    logic [MEM_DW-1:0] wd;
    logic [MEM_AW-1:0] wa;
    logic we;
    logic [MEM_AW-1:0] ra;
    logic re;
    logic doWrite;
    logic doRead;
    logic [MEM_DW-1:0] rVal;
    logic rHit;
    logic [31:0] rd;
    logic err;
    logic [5:0] idx;
    setup = psel & ~penable;
    access = psel & penable & st_r.pready;
    cfg = '0;
    memMode = st_r.ctrl[CT_MEMMODE];
    kind = eab_kind_t'(st_r.ctrl[CT_KIND +: 2]);
    wd = '0;
    wa = '0;
    we = 1'b0;
    ra = '0;
    re = 1'b0;
    doWrite = 1'b0;
    doRead = 1'b0;
    rVal = '0;
    rHit = 1'b0;
    rd = '0;
    err = 1'b0;
    idx = '0;
    st_nxt = st_r;

    // Macrocell registers; a clear overrides the clock enable.
    for (int m = 0; m < NUM_MC; m++) begin
      cfg = st_r.mcCfg[m];
      if (mcClr[m]) begin
        st_nxt.q[m] = 1'b0;
      end else if (mcClkEn) begin
        st_nxt.q[m] = dComb[m] ^ cfg[MC_PRESET];
      end
      if (cfg[MC_COMB]) begin
        st_nxt.mcOut[m] = dComb[m];
      end else begin
        st_nxt.mcOut[m] = st_nxt.q[m] ^ cfg[MC_PRESET];
      end
    end

    // Input stages run on the write or read clock enable.
    if (wrClkEn) begin
      st_nxt.wData = wrData;
      st_nxt.wAddr = wrAddr;
      st_nxt.wEn = wrEn;
    end
    if (rdClkEn) begin
      st_nxt.rAddr = rdAddr;
      st_nxt.rEn = memReadStrobe;
    end
    wd = st_r.ctrl[CT_REG_WDATA] ? st_r.wData : wrData;
    wa = st_r.ctrl[CT_REG_WADDR] ? st_r.wAddr : wrAddr;
    we = st_r.ctrl[CT_REG_WE] ? st_r.wEn : wrEn;
    ra = st_r.ctrl[CT_REG_RADDR] ? st_r.rAddr : rdAddr;
    re = st_r.ctrl[CT_REG_RE] ? st_r.rEn : memReadStrobe;

    // APB: decode in setup, answer in a single access cycle.
    st_nxt.pready = setup;
    if (setup) begin
      if (paddr[1:0] != 2'b00) begin
        err = 1'b1;
      end else if (paddr == ADDR_CTRL) begin
        rd = st_r.ctrl;
      end else if (paddr == ADDR_STATUS) begin
        rd[NUM_MC-1:0] = st_r.mcOut;
        rd[ST_COUNT +: CNT_W] = st_r.count;
        rd[ST_FULL] = st_r.full;
        rd[ST_EMPTY] = st_r.empty;
        rd[ST_HIT] = st_r.hit;
      end else if (paddr >= ADDR_PT_BASE && paddr <= ADDR_PT_END) begin
        idx = paddr[7:2];
        rd = idx[0] ? st_r.ptComp[idx[5:1]] : st_r.ptTrue[idx[5:1]];
      end else if (paddr >= ADDR_MC_BASE && paddr <= ADDR_MC_END) begin
        rd[MC_CFG_W-1:0] = st_r.mcCfg[paddr[5:2]];
      end else if (paddr >= ADDR_MEM_BASE && paddr <= ADDR_MEM_END) begin
        rd[MEM_DW-1:0] = st_r.mem[paddr[5:2]];
      end else begin
        err = 1'b1;
      end
      st_nxt.prdata = rd;
      st_nxt.pslverr = err;
    end else begin
      st_nxt.prdata = '0;
      st_nxt.pslverr = 1'b0;
    end
    if (access && pwrite && !st_r.pslverr) begin
      idx = paddr[7:2];
      if (paddr == ADDR_CTRL) begin
        st_nxt.ctrl = pwdata;
      end else if (paddr >= ADDR_PT_BASE && paddr <= ADDR_PT_END) begin
        if (idx[0]) begin
          st_nxt.ptComp[idx[5:1]] = pwdata;
        end else begin
          st_nxt.ptTrue[idx[5:1]] = pwdata;
        end
      end else if (paddr >= ADDR_MC_BASE && paddr <= ADDR_MC_END) begin
        st_nxt.mcCfg[paddr[5:2]] = pwdata[MC_CFG_W-1:0];
      end else if (paddr >= ADDR_MEM_BASE && paddr <= ADDR_MEM_END) begin
        // Software loading is how a ROM receives its contents.
        st_nxt.mem[paddr[5:2]] = pwdata[MEM_DW-1:0];
      end
    end

    // Memory write side; a user write lands after any software write.
    if (memMode && wrClkEn && we) begin
      unique case (kind)
        KIND_RAM, KIND_SEARCH: doWrite = 1'b1;
        KIND_FIFO: doWrite = ~st_r.full;
        KIND_ROM: doWrite = 1'b0;
      endcase
    end
    if (doWrite) begin
      if (kind == KIND_FIFO) begin
        st_nxt.mem[st_r.wptr] = wd;
        st_nxt.wptr = st_r.wptr + 1'b1;
      end else begin
        st_nxt.mem[wa] = wd;
      end
    end

    // Memory read side, on its own clock enable.
    if (memMode && rdClkEn && re) begin
      doRead = (kind != KIND_FIFO) | ~st_r.empty;
    end
    unique case (kind)
      KIND_FIFO: rVal = st_r.mem[st_r.rptr];
      KIND_SEARCH: begin
        // Lowest matching word wins; the answer is its address.
        for (int i = MEM_DEPTH - 1; i >= 0; i--) begin
          if (st_r.mem[i] == searchKey) begin
            rVal = MEM_DW'(i);
            rHit = 1'b1;
          end
        end
      end
      default: rVal = st_r.mem[ra];
    endcase
    if (doRead && kind == KIND_FIFO) begin
      st_nxt.rptr = st_r.rptr + 1'b1;
    end
    if (rdClkEn) begin
      st_nxt.rdStage = rVal;
      st_nxt.rdStageVld = doRead;
      st_nxt.stageHit = rHit & doRead;
    end
    if (blkClr[0]) begin
      st_nxt.rdData = '0;
      st_nxt.rdValid = 1'b0;
      st_nxt.hit = 1'b0;
    end else if (st_r.ctrl[CT_OUTREG]) begin
      if (rdClkEn) begin
        st_nxt.rdData = st_r.rdStage;
        st_nxt.rdValid = st_r.rdStageVld;
        st_nxt.hit = st_r.stageHit;
      end
    end else if (rdClkEn) begin
      st_nxt.rdData = rVal;
      st_nxt.rdValid = doRead;
      st_nxt.hit = rHit & doRead;
    end

    // FIFO occupancy; push and pop in one cycle leave it unchanged.
    if (doWrite && kind == KIND_FIFO && !(doRead && kind == KIND_FIFO)) begin
      st_nxt.count = st_r.count + 1'b1;
    end else if (!doWrite && doRead && kind == KIND_FIFO) begin
      st_nxt.count = st_r.count - 1'b1;
    end
    st_nxt.full = (st_nxt.count == CNT_W'(MEM_DEPTH));
    st_nxt.empty = (st_nxt.count == '0);
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= '0;
      st_r.ctrl <= CTRL_RESET;
      st_r.empty <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign prdata = st_r.prdata;
  assign pready = st_r.pready;
  assign pslverr = st_r.pslverr;
  assign mcOut = st_r.mcOut;
  assign rdData = st_r.rdData;
  assign rdValid = st_r.rdValid;
  assign searchHit = st_r.hit;
  assign fifoFull = st_r.full;
  assign fifoEmpty = st_r.empty;

endmodule

`default_nettype wire

// >>> tb/eab_checker.sv
// Port assertions for the embedded array block.
// Assumes it is bound to the block; the control word is shadowed here.
`timescale 1ns/1ps
`default_nettype none
module eab_checker (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [3:0] globalSig,
  input wire logic [1:0] clrLocal,
  input wire logic rdClkEn,
  input wire logic memReadStrobe,
  input wire logic [7:0] rdData,
  input wire logic rdValid,
  input wire logic fifoFull,
  input wire logic fifoEmpty
);
  import eab_pkg::*;
  logic [31:0] shadow_r;
  logic clrA;
  // =====
  // Control shadow
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn)
      shadow_r <= CTRL_RESET;
    else if (psel && penable && pready && pwrite && paddr == ADDR_CTRL)
      shadow_r <= pwdata;
  end
  assign clrA = shadow_r[CT_CLR_INV] ^ (shadow_r[CT_CLR_GLB] ?
    globalSig[shadow_r[CT_CLR_IDX0+:2]] : clrLocal[0]);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);
  // =====
  // Properties
  a_apb_ready: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready too long");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_clear_read: assert property (clrA |=> rdData == 0 && !rdValid)
    else $error("clear left read result");
  a_read_hold: assert property (!rdClkEn && !clrA |=>
    $stable(rdData) && $stable(rdValid))
    else $error("read result moved without tick");
  a_read_valid: assert property (shadow_r[8:0] == 9'h001 &&
    rdClkEn && memReadStrobe && !clrA |=> rdValid)
    else $error("read not answered");
  a_pt_quiet: assert property (!shadow_r[CT_MEMMODE] && rdClkEn
    && !shadow_r[CT_OUTREG] |=> !rdValid)
    else $error("read answered in term mode");
  a_fifo_flags: assert property (!(fifoFull && fifoEmpty))
    else $error("fifo full and empty");
  c_read: cover property (rdValid);
  c_full: cover property (fifoFull);
  c_err: cover property (pslverr);
endmodule
bind eab_embedded_array_block eab_checker u_chk (.core_clk, .resetn,
  .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
  .globalSig, .clrLocal, .rdClkEn, .memReadStrobe, .rdData, .rdValid,
  .fifoFull, .fifoEmpty);
`default_nettype wire

// >>> tb/eab_user_logic.sv
// Model of the user logic cells beside the block.
// Assumes one task at a time, or one write forked with one read.
`timescale 1ns/1ps
`default_nettype none
module eab_user_logic (
  input wire logic core_clk,
  output logic [31:0] logicIn,
  output logic [3:0] globalSig,
  output logic [1:0] clrLocal,
  output logic mcClkEn,
  output logic wrClkEn,
  output logic wrEn,
  output logic [3:0] wrAddr,
  output logic [7:0] wrData,
  output logic rdClkEn,
  output logic memReadStrobe,
  output logic [3:0] rdAddr,
  output logic [7:0] searchKey
);
  initial begin
    {logicIn, globalSig, clrLocal, mcClkEn, searchKey} = '0;
    {wrClkEn, wrEn, wrAddr, wrData} = '0;
    {rdClkEn, memReadStrobe, rdAddr} = '0;
  end
  // =====
  // Levels and ticks
  task automatic lv(input logic [31:0] i, input logic [5:0] c,
    input logic m, input logic [7:0] k);
    @(posedge core_clk);
    logicIn <= i;
    {globalSig, clrLocal, mcClkEn, searchKey} <= {c, m, k};
  endtask
  // Released lines turn over so a stale value never passes as fresh.
  task automatic wr(input logic [3:0] a, input logic [7:0] d,
    input logic e, input logic c, input int g);
    repeat (g + 1) @(posedge core_clk);
    {wrClkEn, wrEn, wrAddr, wrData} <= {c, e, a, d};
    @(posedge core_clk);
    {wrClkEn, wrEn, wrAddr, wrData} <= {2'b00, ~a, ~d};
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge core_clk);
    {rdClkEn, memReadStrobe, rdAddr} <= {2'b11, a};
    @(posedge core_clk);
    {rdClkEn, memReadStrobe, rdAddr} <= {2'b00, ~a};
  endtask
endmodule
`default_nettype wire

// >>> tb/eab_embedded_array_block_tb.sv
// Self-checking bench for the embedded array block.
// Assumes the user-logic model drives the block's local side.
`timescale 1ns/1ps
`default_nettype none
module eab_embedded_array_block_tb;
  import eab_pkg::*;
  logic core_clk = 0;
  logic resetn = 0;
  logic psel = 0, penable = 0, pwrite = 0, pready, pslverr, e;
  logic [APB_AW-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd32;
  logic [NUM_IN-1:0] logicIn;
  logic [NUM_GLB-1:0] globalSig;
  logic [1:0] clrLocal;
  logic [NUM_MC-1:0] mcOut;
  logic mcClkEn, wrClkEn, wrEn, rdClkEn, memReadStrobe;
  logic rdValid, searchHit, fifoFull, fifoEmpty;
  logic [MEM_AW-1:0] wrAddr, rdAddr;
  logic [MEM_DW-1:0] wrData, searchKey, rdData, d;
  logic [MEM_DW-1:0] mem [MEM_DEPTH];
  logic [MEM_DW-1:0] fq [$];
  int err_count = 0, checks_done = 0, x, v;
  // Columns: control word, macrocell setup, clear lines, input, output.
  int tab [8][5] = '{'{0, 8'h10, 0, 1, 1}, '{0, 8'h10, 1, 1, 0},
    '{0, 0, 1, 1, 1}, '{0, 8'h20, 1, 1, 1}, '{0, 8'h20, 2, 1, 0},
    '{16'h1000, 8'h10, 4, 1, 0}, '{16'h0400, 8'h10, 0, 1, 0},
    '{0, 8'h50, 1, 0, 1}};
  always #2 core_clk = ~core_clk;
  eab_embedded_array_block uut (.core_clk, .resetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .logicIn,
    .globalSig, .clrLocal, .mcClkEn, .mcOut, .wrClkEn, .wrEn, .wrAddr,
    .wrData, .rdClkEn, .memReadStrobe, .rdAddr, .searchKey, .rdData,
    .rdValid, .searchHit, .fifoFull, .fifoEmpty);
  eab_user_logic ul (.core_clk, .logicIn, .globalSig, .clrLocal, .mcClkEn,
    .wrClkEn, .wrEn, .wrAddr, .wrData, .rdClkEn, .memReadStrobe, .rdAddr,
    .searchKey);
  // =====
  // Tasks
  task automatic chk(input string n, input logic [31:0] ex, g);
    checks_done++;
    if (g !== ex) begin
      err_count++;
      $display("Error %s expected %h seen %h", n, ex, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge core_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, wd};
    @(posedge core_clk);
    penable <= 1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) err_count++;
    {rd32, e} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
  endtask
  task automatic stop_test;
    $display("Checks %0d, errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #200000;
    err_count++;
    stop_test;
  end
  // =====
  // Sequence
  initial begin
    void'($urandom(4095));
    repeat (12) @(posedge core_clk);
    resetn <= 1;
    apb(0, ADDR_CTRL, 0);
    chk("ctrl", CTRL_RESET, rd32);
    apb(0, 12'h040, 0);
    chk("slverr", 32'h8000_0000, {e, rd32[30:0]});
    apb(0, ADDR_STATUS, 0);
    chk("empty", 1, rd32[ST_EMPTY]);
    // Term 1 is x AND NOT x; macrocell 1 lends term 2 (input 1) as a set.
    apb(1, 12'h100, 1);
    apb(1, 12'h108, 1);
    apb(1, 12'h10C, 1);
    apb(1, 12'h110, 2);
    apb(1, 12'h204, 1);
    for (x = 0; x < 16; x++) begin
      apb(1, ADDR_MC_BASE, 8 + 4 * x[2] + 256 * x[0]);
      v = $urandom;
      // No clear is selected here, so the side lines may wander freely.
      ul.lv(v, 6'($urandom), 1'($urandom), 8'($urandom));
      repeat (3) @(posedge core_clk);
      #1;
      chk("mcOut", (v[0] ^ x[2]) | (x[0] & v[1]), mcOut[0]);
    end
    ul.rd(0);
    for (x = 0; x < 8; x++) begin
      apb(1, ADDR_CTRL, tab[x][0]);
      apb(1, ADDR_MC_BASE, tab[x][1]);
      ul.lv(tab[x][3], 0, 1, 0);
      repeat (3) @(posedge core_clk);
      ul.lv(tab[x][3], 6'(tab[x][2]), 0, 0);
      repeat (3) @(posedge core_clk);
      #1;
      chk("mcClr", tab[x][4], mcOut[0]);
    end
    ul.lv(0, 0, 0, 0);
    apb(1, ADDR_CTRL, 1);
    for (x = 0; x < 16; x++) begin
      d = 8'($urandom);
      mem[x] = d;
      ul.wr(4'(x), d, 1, 1, $urandom_range(3));
      ul.wr(4'(x), ~d, 0, 1, 0);
      ul.wr(4'(x), ~d, 1, 0, 0);
    end
    for (x = 0; x < 16; x++) begin
      d = 8'($urandom);
      fork
        ul.rd(4'(x));
        ul.wr(4'(x + 1), d, 1, 1, 0);
      join
      #1;
      chk("rdData", mem[x], rdData);
      chk("rdValid", 1, rdValid);
      mem[4'(x + 1)] = d;
    end
    apb(1, ADDR_CTRL, 9);
    ul.rd(5);
    ul.rd(6);
    #1;
    chk("pipeData", mem[5], rdData);
    // Staged write inputs act one write tick late.
    apb(1, ADDR_CTRL, 32'h0000_00B1);
    ul.wr(3, ~mem[3], 1, 1, 0);
    ul.rd(3);
    #1;
    chk("stagedOld", mem[3], rdData);
    mem[3] = ~mem[3];
    ul.wr(3, ~mem[3], 0, 1, 0);
    ul.rd(3);
    #1;
    chk("stagedNew", mem[3], rdData);
    apb(1, ADDR_CTRL, 3);
    ul.wr(2, ~mem[2], 1, 1, 0);
    ul.rd(2);
    #1;
    chk("romData", mem[2], rdData);
    apb(1, ADDR_CTRL, 7);
    for (x = 0; x < 6; x++) begin
      d = x[0] ? mem[$urandom_range(15)] : 8'($urandom);
      v = 16;
      for (int i = 15; i >= 0; i--) if (mem[i] === d) v = i;
      ul.lv(0, 0, 0, d);
      ul.rd(0);
      #1;
      chk("hit", v < 16, searchHit);
      chk("index", v < 16 ? v : 0, rdData);
    end
    apb(1, ADDR_CTRL, 5);
    for (x = 0; x < 17; x++) begin
      d = 8'($urandom);
      if (x < 16) fq.push_back(d);
      ul.wr(0, d, 1, 1, 0);
    end
    #1;
    chk("full", 1, fifoFull);
    while (fq.size() > 0) begin
      ul.rd(0);
      #1;
      chk("fifoData", fq.pop_front(), rdData);
    end
    ul.rd(0);
    #1;
    chk("popEmpty", 2'b10, {fifoEmpty, rdValid});
    stop_test;
  end
endmodule
`default_nettype wire
